// ---- common/sbi_pkg.sv ----
// Purpose: shared constants and types for the system bus i/o interface
// Assumes: 40 MHz core clock, bus cycle framed by master_bus_clock
// Notes: tag and response lines are active low on the bus
package sbi_pkg;
  localparam int CLK_PERIOD_NS = 25;
  localparam int BUS_CYCLE_NS = 150;
  localparam int MEM_CYCLE_NS = 600;
  localparam int BUS_CYCLE_CLKS = (BUS_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int XFERS_PER_MEM = MEM_CYCLE_NS / BUS_CYCLE_NS;
  localparam int DATA_W = 32;
  localparam int DEST_W = 24;
  localparam int HALF_W = 16;
  localparam int PRI_W = 7;
  localparam int ADDR_LSB = 8;
  localparam int ADDR_W = 7;
  localparam int FIFO_DEPTH = 8;
  localparam int ORDER_W = 4;
  localparam int TEST_SEL_W = 4;
  localparam logic [6:0] OWN_ADDR_RST = 7'h00;
  // tag vector order: valid, memory, ctl0, ctl1, read, error (active low)
  localparam logic [5:0] TAG_WRITE_DATA_OR_ORDER_TRANSFER = 6'h1F;
  localparam logic [5:0] TAG_ICT = 6'h1B;
  localparam logic [5:0] TAG_RSTX = 6'h19;
  localparam logic [5:0] TAG_ARSTX = 6'h17;
  localparam logic [5:0] TAG_AICT = 6'h15;
  localparam logic [5:0] TAG_DRT = 6'h13;
  localparam logic [5:0] TAG_ERRX = 6'h3E;
  localparam logic [5:0] TAG_MWT = 6'h0F;
  localparam logic [5:0] TAG_MRT = 6'h0D;
  typedef struct packed {
    logic [5:0] tag_n;
    logic [DEST_W-1:0] dest;
    logic [DATA_W-1:0] data;
  } sbi_xfer_s;
  typedef struct packed {
    logic [ORDER_W-1:0] ctl;
    logic wide;
    logic [DATA_W-1:0] data;
  } sbi_pout_s;
  typedef enum logic [2:0] {ST_IDLE, ST_HELD, ST_ASSEMBLE, ST_ARB, ST_DRIVE} sbi_stage_e;
endpackage : sbi_pkg

// ---- verilog/sbi_top.sv ----
// Purpose: system bus interface of a peripheral i/o controller card
// Assumes: bus inputs asynchronous to I_CLK; microprocessor logic on I_CLK
// Notes: transfer formats and device logic are outside this block
`timescale 1ns/1ps
`default_nettype none

// ---------------------------------------------------------------
// fifo for peripheral output words
// ---------------------------------------------------------------
module sbi_fifo #(
  parameter int WIDTH = 37,
  parameter int DEPTH = 8
) (
  input wire logic I_CLK,
  input wire logic I_RESET_N,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_reg, rd_reg;
  logic [AW:0] cnt_reg;
  wire push = i_in_valid && o_in_ready;
  wire pop = o_out_valid && i_out_ready;
  assign o_in_ready = (cnt_reg != DEPTH[AW:0]);
  assign o_out_valid = (cnt_reg != '0);
  assign o_out_data = mem[rd_reg];
  // pointers and count
  always_ff @(posedge I_CLK) begin
    if (!I_RESET_N) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) wr_reg <= (wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + 1'b1;
      if (pop) rd_reg <= (rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + 1'b1;
      cnt_reg <= cnt_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
  // storage
  always_ff @(posedge I_CLK) begin
    if (push) mem[wr_reg] <= i_in_data;
  end
endmodule // sbi_fifo

// ---------------------------------------------------------------
// top
// ---------------------------------------------------------------
module sbi_top (
  input wire logic I_CLK,
  input wire logic I_RESET_N,
  // bus cycle framing and tags
  input wire logic I_MCLK,
  input wire logic [5:0] I_TAG_N,
  output logic [5:0] O_TAG_N,
  output logic O_TAG_OE,
  input wire logic [31:0] I_DATA,
  output logic [31:0] O_DATA,
  output logic O_DATA_OE,
  input wire logic [23:0] I_DEST,
  output logic [23:0] O_DEST,
  output logic O_DEST_OE,
  // responses, active low, own drive
  output logic O_BUSY_N,
  output logic O_RETRY_N,
  output logic O_TA_N,
  output logic O_READY_N,
  output logic O_UMT_N,
  // arbitration
  output logic O_BUS_REQ,
  input wire logic I_BUS_GRANT,
  // interrupts
  input wire logic I_INT_WINDOW,
  input wire logic I_HIGHER_INT,
  output logic O_SERVICE_INT,
  output logic [6:0] O_INT_LEVEL,
  // microprocessor side
  input wire logic I_UP_CYCLE,
  input wire logic [3:0] I_ORDER_SEL,
  input wire logic I_ORDER_PULSE,
  input wire logic I_ORDER_LEVEL,
  input wire logic I_ORDER_LEVEL_VAL,
  output logic [15:0] O_ORDER,
  input wire logic [3:0] I_TEST_SEL,
  input wire logic I_TEST_STROBE,
  output logic O_TEST_RESULT,
  input wire logic I_EXPECT,
  input wire logic [6:0] I_OWN_ADDR,
  output logic O_MICRO_INT,
  output logic [31:0] O_STAGE_DATA,
  output logic [23:0] O_STAGE_DEST,
  output logic [5:0] O_STAGE_TAG_N,
  input wire logic I_CLEAR_BUSY,
  input wire logic I_ASSEMBLE,
  input wire logic I_OUT_LOAD,
  input wire logic [5:0] I_OUT_TAG_N,
  input wire logic [31:0] I_OUT_DATA,
  input wire logic [23:0] I_OUT_DEST,
  input wire logic I_OUT_GO,
  input wire logic I_SI_REQ,
  input wire logic [6:0] I_SI_LEVEL,
  input wire logic I_SI_CLEAR,
  input wire logic I_READY_SET,
  // peripheral output path
  input wire logic I_POUT_VALID,
  output logic O_POUT_READY,
  input wire logic I_POUT_WIDE,
  input wire logic [15:0] I_POUT_A,
  input wire logic [15:0] I_POUT_B,
  input wire logic I_POUT_USE_A,
  input wire logic [3:0] I_POUT_CTL,
  output logic O_PDEV_VALID,
  input wire logic I_PDEV_READY,
  output logic [31:0] O_PDEV_DATA,
  output logic O_PDEV_WIDE,
  output logic [3:0] O_PDEV_CTL,
  // peripheral input path
  input wire logic I_PIN_REQ,
  input wire logic I_PIN_STATUS,
  output logic O_PIN_SEL_STATUS,
  input wire logic [15:0] I_PIN_DATA,
  output logic O_BFILE_WE,
  output logic [15:0] O_BFILE_WDATA
);
  // ---------------------------------------------------------------
  // synchronisers
  // ---------------------------------------------------------------
  logic [1:0] mclk_s;
  logic [1:0] win_s, hi_s, grant_s;
  logic [5:0] tag_s1, tag_s2;
  logic [31:0] data_s1, data_s2;
  logic [23:0] dest_s1, dest_s2;
  logic mclk_d_reg;
  // two flops per outside input
  always_ff @(posedge I_CLK) begin
    mclk_s <= {mclk_s[0], I_MCLK};
    win_s <= {win_s[0], I_INT_WINDOW};
    hi_s <= {hi_s[0], I_HIGHER_INT};
    grant_s <= {grant_s[0], I_BUS_GRANT};
    tag_s1 <= I_TAG_N;
    tag_s2 <= tag_s1;
    data_s1 <= I_DATA;
    data_s2 <= data_s1;
    dest_s1 <= I_DEST;
    dest_s2 <= dest_s1;
  end
  always_ff @(posedge I_CLK) begin
    if (!I_RESET_N) mclk_d_reg <= 1'b1; // idle high, no false rise after reset
    else mclk_d_reg <= mclk_s[1];
  end
  // one master clock rise marks end of one bus cycle and start of next
  wire cyc_edge = mclk_s[1] && !mclk_d_reg;

  // ---------------------------------------------------------------
  // tag decode
  // ---------------------------------------------------------------
  // tag patterns
  wire tag_valid = !tag_s2[5];
  wire is_input = tag_valid && !tag_s2[4];
  wire is_err = (tag_s2 == sbi_pkg::TAG_ERRX);
  wire addr_hit = (dest_s2[sbi_pkg::ADDR_LSB +: sbi_pkg::ADDR_W] == I_OWN_ADDR);
  wire for_us = (tag_valid && addr_hit && tag_s2[4]) || is_err;

  // ---------------------------------------------------------------
  // staging register and state
  // ---------------------------------------------------------------
  sbi_pkg::sbi_stage_e st_reg, st_next;
  sbi_pkg::sbi_xfer_s stage_reg, stage_next;
  logic ta_reg, rej_reg, arrived_reg, mint_reg, ready_reg;
  logic rej_held_reg; // reject kind frozen for the whole response cycle
  wire stage_busy = (st_reg != sbi_pkg::ST_IDLE);
  wire accept = cyc_edge && for_us && !stage_busy;
  wire reject = cyc_edge && for_us && stage_busy;
  // state transitions
  always_comb begin
    st_next = st_reg;
    stage_next = stage_reg;
    case (st_reg)
      sbi_pkg::ST_IDLE: begin
        if (accept) begin
          stage_next = '{tag_n: tag_s2, dest: dest_s2, data: data_s2};
          st_next = sbi_pkg::ST_HELD;
        end else if (I_ASSEMBLE) begin
          st_next = sbi_pkg::ST_ASSEMBLE;
        end
      end
      sbi_pkg::ST_HELD: begin
        if (I_CLEAR_BUSY) st_next = sbi_pkg::ST_IDLE;
      end
      sbi_pkg::ST_ASSEMBLE: begin
        if (I_OUT_LOAD) begin
          stage_next = '{tag_n: I_OUT_TAG_N, dest: I_OUT_DEST, data: I_OUT_DATA};
        end
        if (I_OUT_GO) st_next = sbi_pkg::ST_ARB;
      end
      sbi_pkg::ST_ARB: begin
        if (grant_s[1] && cyc_edge) st_next = sbi_pkg::ST_DRIVE;
      end
      sbi_pkg::ST_DRIVE: begin
        if (cyc_edge) st_next = sbi_pkg::ST_IDLE;
      end
      default: st_next = sbi_pkg::ST_IDLE;
    endcase
  end
  // state registers
  always_ff @(posedge I_CLK) begin
    if (!I_RESET_N) begin
      st_reg <= sbi_pkg::ST_IDLE;
      stage_reg <= '0;
    end else begin
      st_reg <= st_next;
      stage_reg <= stage_next;
    end
  end

  // ---------------------------------------------------------------
  // responses and arrival
  // ---------------------------------------------------------------
  // ack one cycle later, none on reject
  always_ff @(posedge I_CLK) begin
    if (!I_RESET_N) begin
      ta_reg <= 1'b0;
      rej_reg <= 1'b0;
      rej_held_reg <= 1'b0;
    end else if (cyc_edge) begin
      ta_reg <= accept;
      rej_reg <= reject;
      rej_held_reg <= (st_reg == sbi_pkg::ST_HELD);
    end
  end
  // arrival flags, set wins over clear
  always_ff @(posedge I_CLK) begin
    if (!I_RESET_N) begin
      arrived_reg <= 1'b0;
      mint_reg <= 1'b0;
    end else begin
      arrived_reg <= (accept && I_EXPECT) || (arrived_reg && !I_CLEAR_BUSY);
      mint_reg <= (accept && !I_EXPECT) || (mint_reg && !I_CLEAR_BUSY);
    end
  end
  // ready response held until next accepted transfer
  always_ff @(posedge I_CLK) begin
    if (!I_RESET_N) ready_reg <= 1'b0;
    else ready_reg <= I_READY_SET || (ready_reg && !accept);
  end
  assign O_TA_N = !ta_reg;
  assign O_BUSY_N = !(rej_reg && rej_held_reg);
  assign O_RETRY_N = !(rej_reg && !rej_held_reg);
  assign O_READY_N = !ready_reg;
  assign O_UMT_N = 1'b1;
  assign O_MICRO_INT = mint_reg;
  assign O_STAGE_DATA = stage_reg.data;
  assign O_STAGE_DEST = stage_reg.dest;
  assign O_STAGE_TAG_N = stage_reg.tag_n;

  // ---------------------------------------------------------------
  // bus drive
  // ---------------------------------------------------------------
  // drive whole cycle
  wire driving = (st_reg == sbi_pkg::ST_DRIVE);
  assign O_BUS_REQ = (st_reg == sbi_pkg::ST_ARB);
  assign O_DATA = stage_reg.data;
  assign O_DEST = stage_reg.dest;
  assign O_TAG_N = stage_reg.tag_n;
  assign O_DATA_OE = driving;
  assign O_DEST_OE = driving;
  assign O_TAG_OE = driving;

  // ---------------------------------------------------------------
  // service interrupt
  // ---------------------------------------------------------------
  logic si_req_reg;
  logic [6:0] si_lvl_reg;
  // pending request and level
  always_ff @(posedge I_CLK) begin
    if (!I_RESET_N) begin
      si_req_reg <= 1'b0;
      si_lvl_reg <= '0;
    end else begin
      si_req_reg <= I_SI_REQ || (si_req_reg && !I_SI_CLEAR);
      if (I_SI_REQ) si_lvl_reg <= I_SI_LEVEL;
    end
  end
  assign O_SERVICE_INT = si_req_reg && win_s[1] && !hi_s[1];
  assign O_INT_LEVEL = si_lvl_reg;

  // ---------------------------------------------------------------
  // order and test structures
  // ---------------------------------------------------------------
  logic [15:0] lvl_reg, pulse_reg;
  logic test_reg;
  always_ff @(posedge I_CLK) begin
    if (!I_RESET_N) begin
      lvl_reg <= '0;
      pulse_reg <= '0;
    end else begin
      pulse_reg <= (I_UP_CYCLE && I_ORDER_PULSE) ? (16'h0001 << I_ORDER_SEL) : 16'h0000;
      if (I_UP_CYCLE && I_ORDER_LEVEL) lvl_reg[I_ORDER_SEL] <= I_ORDER_LEVEL_VAL;
    end
  end
  assign O_ORDER = lvl_reg | pulse_reg;
  wire [15:0] test_vec = {8'h00, I_PIN_REQ, grant_s[1], ready_reg, si_req_reg,
    mint_reg, stage_busy, is_input, arrived_reg};
  always_ff @(posedge I_CLK) begin
    if (!I_RESET_N) test_reg <= 1'b0;
    else if (I_TEST_STROBE) test_reg <= test_vec[I_TEST_SEL];
  end
  assign O_TEST_RESULT = test_reg;

  // ---------------------------------------------------------------
  // peripheral output path
  // ---------------------------------------------------------------
  sbi_pkg::sbi_pout_s pout_in, pout_out;
  logic pdev_valid;
  assign pout_in.ctl = I_POUT_CTL;
  assign pout_in.wide = I_POUT_WIDE;
  assign pout_in.data = I_POUT_WIDE ? {I_POUT_A, I_POUT_B}
    : {16'h0000, (I_POUT_USE_A ? I_POUT_A : I_POUT_B)};
  sbi_fifo #(.WIDTH($bits(sbi_pkg::sbi_pout_s)), .DEPTH(sbi_pkg::FIFO_DEPTH)) u_fifo (
    .I_CLK(I_CLK),
    .I_RESET_N(I_RESET_N),
    .i_in_valid(I_POUT_VALID),
    .o_in_ready(O_POUT_READY),
    .i_in_data(pout_in),
    .o_out_valid(pdev_valid),
    .i_out_ready(I_PDEV_READY),
    .o_out_data(pout_out)
  );
  assign O_PDEV_VALID = pdev_valid;
  assign O_PDEV_DATA = pout_out.data;
  assign O_PDEV_WIDE = pout_out.wide;
  assign O_PDEV_CTL = pout_out.ctl;

  // ---------------------------------------------------------------
  // peripheral input path
  // ---------------------------------------------------------------
  logic bwe_reg;
  logic [15:0] bdat_reg;
  // write B file with selected kind
  always_ff @(posedge I_CLK) begin
    if (!I_RESET_N) begin
      bwe_reg <= 1'b0;
      bdat_reg <= '0;
    end else begin
      bwe_reg <= I_PIN_REQ;
      if (I_PIN_REQ) bdat_reg <= I_PIN_DATA;
    end
  end
  assign O_PIN_SEL_STATUS = I_PIN_STATUS;
  assign O_BFILE_WE = bwe_reg;
  assign O_BFILE_WDATA = bdat_reg;
endmodule // sbi_top
`default_nettype wire

// ---- verif/sbi_top_assertions.sv ----
// Purpose: port checks for the system bus i/o interface
// Assumes: bus master clock framed at 6 core clocks per bus cycle
// Notes: bound to sbi_top from the testbench file
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// checker
// ----------------------------------------
module sbi_top_chk (
  input wire logic I_CLK,
  input wire logic I_RESET_N,
  input wire logic O_DATA_OE,
  input wire logic O_DEST_OE,
  input wire logic O_TAG_OE,
  input wire logic [31:0] O_DATA,
  input wire logic O_BUS_REQ,
  input wire logic O_TA_N,
  input wire logic O_BUSY_N,
  input wire logic O_RETRY_N,
  input wire logic O_SERVICE_INT,
  input wire logic I_INT_WINDOW,
  input wire logic I_HIGHER_INT,
  input wire logic I_PIN_REQ,
  input wire logic [15:0] I_PIN_DATA,
  input wire logic O_BFILE_WE,
  input wire logic [15:0] O_BFILE_WDATA,
  input wire logic O_MICRO_INT,
  input wire logic I_EXPECT
);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RESET_N);
  // bus drive relations
  oe_group_a: assert property (O_DATA_OE |-> O_DEST_OE && O_TAG_OE)
    else $error("bus enables split");
  drive_grant_a: assert property ($rose(O_DATA_OE) |-> $past(O_BUS_REQ))
    else $error("drive without arbitration");
  drive_hold_a: assert property (O_DATA_OE && $past(O_DATA_OE) |-> $stable(O_DATA))
    else $error("driven data moved");
  drive_len_a: assert property ($rose(O_DATA_OE) |-> O_DATA_OE [*5])
    else $error("drive shorter than bus cycle");
  // response relations
  ta_alone_a: assert property (!O_TA_N |-> O_BUSY_N && O_RETRY_N)
    else $error("acknowledge with reject");
  ta_len_a: assert property ($fell(O_TA_N) |-> !O_TA_N [*5])
    else $error("acknowledge shorter than bus cycle");
  // interrupt gating, allowing synchroniser delay
  si_window_a: assert property (O_SERVICE_INT |-> $past(I_INT_WINDOW, 2))
    else $error("service interrupt outside window");
  si_higher_a: assert property (O_SERVICE_INT |-> !$past(I_HIGHER_INT, 2))
    else $error("service interrupt over higher level");
  // peripheral input and microinterrupt
  bfile_write_a: assert property (I_PIN_REQ |=> O_BFILE_WE && O_BFILE_WDATA == $past(I_PIN_DATA))
    else $error("b file write missing");
  micro_cause_a: assert property ($rose(O_MICRO_INT) |-> !I_EXPECT)
    else $error("microinterrupt on expected arrival");
  cover property ($fell(O_TA_N));
  cover property ($fell(O_RETRY_N));
  cover property ($rose(O_DATA_OE));
  cover property ($rose(O_SERVICE_INT));
endmodule // sbi_top_chk
`default_nettype wire

// ---- verif/sbi_bus_model.sv ----
// Purpose: cpu and memory bus controller side of the shared bus
// Assumes: one transfer queued at a time through send
// Notes: released dest and data lines show the inverse of their last value, tag lines read all high
`timescale 1ns/1ps
`default_nettype none
module sbi_bus_model #(
  parameter int GNT_DLY = 3
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_bus_req,
  output logic o_mclk,
  output logic o_grant,
  output sbi_pkg::sbi_xfer_s o_xfer
);
  logic [2:0] phase_reg;
  logic [3:0] gnt_reg;
  logic pend;
  sbi_pkg::sbi_xfer_s pend_x;
  // six core clocks per bus cycle
  assign o_mclk = phase_reg < 3'h3;
  always @(posedge i_clk) begin
    phase_reg <= (!i_reset_n || phase_reg == 3'h5) ? 3'h0 : phase_reg + 3'h1;
    if (!i_reset_n) begin
      o_xfer <= {6'h3F, 24'h0, 32'h0};
      pend <= 1'b0;
    end else if (phase_reg == 3'h1) begin
      o_xfer <= pend ? pend_x : {6'h3F, ~o_xfer.dest, ~o_xfer.data};
      // clear only what was taken, so a request made at this edge is kept
      if (pend) pend <= 1'b0;
    end
  end
  // grant after a delay while requested
  always @(posedge i_clk) begin
    gnt_reg <= (!i_reset_n || !i_bus_req) ? 4'h0 : gnt_reg + {3'h0, gnt_reg != 4'hF};
    o_grant <= i_reset_n && i_bus_req && gnt_reg >= GNT_DLY;
  end
  // queue one transfer, return once on the bus
  task automatic send(input sbi_pkg::sbi_xfer_s x);
    @(posedge i_clk);
    pend_x <= x;
    pend <= 1'b1;
    repeat (8) @(posedge i_clk);
  endtask
endmodule // sbi_bus_model
`default_nettype wire

// ---- verif/testbench.sv ----
// Purpose: self-checking bench for sbi_top
// Assumes: 40 MHz core clock, bus model framing the cycles
// Notes: each scenario drives and judges on its own
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam logic [23:0] OWN_DEST = 24'h002A00;
  logic I_CLK = 0, I_RESET_N = 0, I_INT_WINDOW = 0, I_HIGHER_INT = 0, I_UP_CYCLE = 0;
  logic I_ORDER_PULSE = 0, I_ORDER_LEVEL = 0, I_ORDER_LEVEL_VAL = 0, I_TEST_STROBE = 0;
  logic I_EXPECT = 0, I_CLEAR_BUSY = 0, I_ASSEMBLE = 0, I_OUT_LOAD = 0, I_OUT_GO = 0;
  logic I_SI_REQ = 0, I_SI_CLEAR = 0, I_READY_SET = 0, I_POUT_VALID = 0, I_POUT_WIDE = 0;
  logic I_POUT_USE_A = 0, I_PDEV_READY = 0, I_PIN_REQ = 0, I_PIN_STATUS = 0, I_BUS_GRANT;
  logic [3:0] I_ORDER_SEL = 0, I_TEST_SEL = 0, I_POUT_CTL = 0;
  logic [6:0] I_OWN_ADDR = 7'h2A, I_SI_LEVEL = 0;
  logic [5:0] I_OUT_TAG_N = 6'h3F;
  logic [31:0] I_OUT_DATA = 0;
  logic [23:0] I_OUT_DEST = 0;
  logic [15:0] I_POUT_A = 0, I_POUT_B = 0, I_PIN_DATA = 0;
  logic [5:0] O_TAG_N, O_STAGE_TAG_N;
  logic [31:0] O_DATA, O_STAGE_DATA, O_PDEV_DATA;
  logic [23:0] O_DEST, O_STAGE_DEST;
  logic [15:0] O_ORDER, O_BFILE_WDATA;
  logic [6:0] O_INT_LEVEL;
  logic [3:0] O_PDEV_CTL;
  logic O_TAG_OE, O_DATA_OE, O_DEST_OE, O_BUSY_N, O_RETRY_N, O_TA_N, O_READY_N, O_UMT_N;
  logic O_BUS_REQ, O_SERVICE_INT, O_TEST_RESULT, O_MICRO_INT, O_POUT_READY, O_PDEV_VALID;
  logic O_PDEV_WIDE, O_PIN_SEL_STATUS, O_BFILE_WE, I_MCLK, ta, bsy, rty;
  wire logic [5:0] I_TAG_N;
  wire logic [31:0] I_DATA;
  wire logic [23:0] I_DEST;
  sbi_pkg::sbi_xfer_s bus_x;
  int mismatches = 0, checks = 0;
  logic [5:0] tags [7] = '{sbi_pkg::TAG_WRITE_DATA_OR_ORDER_TRANSFER, sbi_pkg::TAG_ICT, sbi_pkg::TAG_RSTX,
    sbi_pkg::TAG_ARSTX, sbi_pkg::TAG_AICT, sbi_pkg::TAG_DRT, sbi_pkg::TAG_ERRX};
  // ----------------------------------------
  // clock, wires, instances
  // ----------------------------------------
  always #12.5 I_CLK = ~I_CLK;
  // wire level from both parties
  assign I_TAG_N = O_TAG_OE ? O_TAG_N : bus_x.tag_n;
  assign I_DATA = O_DATA_OE ? O_DATA : bus_x.data;
  assign I_DEST = O_DEST_OE ? O_DEST : bus_x.dest;
  sbi_top u_dut (.*);
  sbi_bus_model u_bus (.i_clk(I_CLK), .i_reset_n(I_RESET_N), .i_bus_req(O_BUS_REQ),
    .o_mclk(I_MCLK), .o_grant(I_BUS_GRANT), .o_xfer(bus_x));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic clk(input int n);
    repeat (n) @(posedge I_CLK);
  endtask
  // send one transfer and gather the responses over three bus cycles
  task automatic xfer(input logic [5:0] t, input logic [23:0] d, input logic [31:0] v);
    u_bus.send({t, d, v});
    {ta, bsy, rty} = 3'h0;
    repeat (18) begin
      @(negedge I_CLK);
      ta |= O_TA_N === 1'b0;
      bsy |= O_BUSY_N === 1'b0;
      rty |= O_RETRY_N === 1'b0;
    end
    @(posedge I_CLK);
  endtask
  task automatic test_bit(input logic [3:0] sel, input logic exp);
    I_TEST_SEL <= sel;
    I_TEST_STROBE <= 1;
    clk(1);
    I_TEST_STROBE <= 0;
    clk(2);
    chk(O_TEST_RESULT, exp);
  endtask
  task automatic clear_busy();
    I_CLEAR_BUSY <= 1;
    clk(1);
    I_CLEAR_BUSY <= 0;
    clk(3);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_tags();
    I_EXPECT <= 1;
    I_READY_SET <= 1;
    clk(1);
    I_READY_SET <= 0;
    clk(3);
    chk(O_READY_N, 0);
    for (int k = 0; k < 7; k++) begin
      xfer(tags[k], OWN_DEST, 32'h5A00_0000 + k);
      chk(ta, 1);
      chk(O_STAGE_TAG_N, tags[k]);
      chk(O_STAGE_DATA, 32'h5A00_0000 + k);
      chk(O_STAGE_DEST, OWN_DEST);
      chk(O_MICRO_INT, 0);
      if (k == 0) chk(O_READY_N, 1);
      if (k == 0) test_bit(4'h0, 1);
      clear_busy();
    end
    test_bit(4'h2, 0);
  endtask
  task automatic t_unexpected();
    I_EXPECT <= 0;
    xfer(sbi_pkg::TAG_WRITE_DATA_OR_ORDER_TRANSFER, OWN_DEST ^ 24'h000100, 32'h1);
    chk(ta, 0);
    xfer(sbi_pkg::TAG_WRITE_DATA_OR_ORDER_TRANSFER, OWN_DEST, 32'h2);
    chk(ta, 1);
    chk(O_MICRO_INT, 1);
    xfer(sbi_pkg::TAG_ICT, OWN_DEST, 32'h3);
    chk({bsy, ta}, 2'b10);
    chk(O_STAGE_DATA, 32'h2);
    test_bit(4'h2, 1);
    clear_busy();
    chk(O_MICRO_INT, 0);
    xfer(sbi_pkg::TAG_ICT, OWN_DEST, 32'h3);
    chk(ta, 1);
    clear_busy();
  endtask
  task automatic t_output();
    I_ASSEMBLE <= 1;
    clk(1);
    I_ASSEMBLE <= 0;
    I_OUT_LOAD <= 1;
    {I_OUT_TAG_N, I_OUT_DEST, I_OUT_DATA} <= {sbi_pkg::TAG_MWT, 24'h012345, 32'hA5A50F0F};
    clk(1);
    I_OUT_LOAD <= 0;
    xfer(sbi_pkg::TAG_WRITE_DATA_OR_ORDER_TRANSFER, OWN_DEST, 32'h4);
    chk({rty, ta}, 2'b10);
    I_OUT_GO <= 1;
    clk(1);
    I_OUT_GO <= 0;
    for (int n = 0; n < 20 && O_BUS_REQ !== 1'b1; n++) @(negedge I_CLK);
    chk({O_BUS_REQ, O_DATA_OE}, 2'b10);
    for (int n = 0; n < 40 && O_DATA_OE !== 1'b1; n++) @(negedge I_CLK);
    chk(O_DATA, 32'hA5A50F0F);
    chk(O_DEST, 24'h012345);
    chk(O_TAG_N, sbi_pkg::TAG_MWT);
    for (int n = 0; n < 20 && O_DATA_OE !== 1'b0; n++) @(negedge I_CLK);
    chk(O_DATA_OE, 0);
    clk(1);
  endtask
  task automatic t_si();
    I_SI_LEVEL <= 7'h15;
    I_SI_REQ <= 1;
    clk(1);
    I_SI_REQ <= 0;
    clk(6);
    chk(O_SERVICE_INT, 0);
    {I_INT_WINDOW, I_HIGHER_INT} <= 2'b11;
    clk(6);
    chk(O_SERVICE_INT, 0);
    I_HIGHER_INT <= 0;
    clk(6);
    chk({O_SERVICE_INT, O_INT_LEVEL}, {1'b1, 7'h15});
    I_SI_CLEAR <= 1;
    clk(1);
    I_SI_CLEAR <= 0;
    clk(3);
    chk(O_SERVICE_INT, 0);
    I_INT_WINDOW <= 0;
  endtask
  task automatic t_order();
    {I_ORDER_SEL, I_ORDER_PULSE} <= {4'h3, 1'b1};
    clk(1);
    I_ORDER_PULSE <= 0;
    @(negedge I_CLK) chk(O_ORDER, 16'h0008);
    @(negedge I_CLK) chk(O_ORDER, 16'h0000);
    clk(1);
    {I_ORDER_SEL, I_ORDER_LEVEL, I_ORDER_LEVEL_VAL} <= {4'h5, 2'b11};
    clk(1);
    I_ORDER_LEVEL <= 0;
    clk(4);
    chk(O_ORDER, 16'h0020);
    {I_ORDER_LEVEL, I_ORDER_LEVEL_VAL} <= 2'b10;
    clk(1);
    I_ORDER_LEVEL <= 0;
    clk(2);
    chk(O_ORDER, 16'h0000);
    {I_UP_CYCLE, I_ORDER_PULSE} <= 2'b01;
    clk(1);
    {I_UP_CYCLE, I_ORDER_PULSE} <= 2'b10;
    @(negedge I_CLK) chk(O_ORDER, 16'h0000);
    clk(1);
  endtask
  task automatic t_fifo();
    int n = 0;
    logic [15:0] a, b;
    for (int k = 0; k < 10; k++) begin
      {I_POUT_VALID, I_POUT_WIDE, I_POUT_USE_A, I_POUT_CTL} <= {1'b1, k[0], k[1], k[3:0]};
      {I_POUT_A, I_POUT_B} <= {16'hA000 + k[15:0], 16'hB000 + k[15:0]};
      @(negedge I_CLK);
      if (O_POUT_READY !== 1'b1) break;
      @(posedge I_CLK) n++;
    end
    chk(n, sbi_pkg::FIFO_DEPTH);
    @(posedge I_CLK) {I_POUT_VALID, I_PDEV_READY} <= 2'b01;
    for (int j = 0; j < 8; j++) begin
      {a, b} = {16'hA000 + j[15:0], 16'hB000 + j[15:0]};
      @(negedge I_CLK);
      chk({O_PDEV_VALID, O_PDEV_WIDE, O_PDEV_CTL}, {1'b1, j[0], j[3:0]});
      chk(j[0] ? O_PDEV_DATA : O_PDEV_DATA[15:0], j[0] ? {a, b} : (j[1] ? a : b));
      @(posedge I_CLK);
    end
    @(negedge I_CLK) chk(O_PDEV_VALID, 0);
    clk(1);
  endtask
  task automatic t_pin();
    {I_PIN_REQ, I_PIN_DATA, I_PIN_STATUS} <= {1'b1, 16'hBEEF, 1'b1};
    clk(1);
    I_PIN_REQ <= 0;
    @(negedge I_CLK) chk({O_BFILE_WE, O_BFILE_WDATA}, {1'b1, 16'hBEEF});
    chk(O_PIN_SEL_STATUS, 1);
    clk(1);
  endtask
  // ----------------------------------------
  // run control
  // ----------------------------------------
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // hang guard
  initial begin
    #200000;
    mismatches++;
    tally_and_finish();
  end
  // main sequence
  initial begin
    clk(20);
    {I_RESET_N, I_UP_CYCLE} <= 2'b11;
    clk(3);
    chk({O_DATA_OE, O_TA_N, O_BUSY_N, O_RETRY_N, O_UMT_N, O_ORDER}, {5'h0F, 16'h0000});
    t_tags();
    t_unexpected();
    t_output();
    t_si();
    t_order();
    t_fifo();
    t_pin();
    tally_and_finish();
  end
endmodule // testbench
bind sbi_top sbi_top_chk u_chk (.*);
`default_nettype wire
